// File: nvol_option_loader.v
// Purpose: reset-time load of watchdog key and rc trimming from the option area
// Assumes: flash read port on the same clock; standby input from same-clock logic
// Notes: apb slave with zero wait states; no path writes the flash other than the erase request
//
// Summary of operation
// - copy flash FFBE/FFBF into watchdog key bytes
// - software writes to key registers are ignored
// - key A596: software watchdog, hardware watchdog off
// - key A597: hardware watchdog, halts in standby
// - other keys: hardware watchdog runs through standby
// - load 11-bit trim: 5 coarse, 6 fine
// - all-ones trim gives lowest rc frequency
// - all-zeros trim gives highest rc frequency
// - new frequency select changes rc, may be unstable
// - trim changes are never written back to flash
// - flash erase also erases whole option area
// - select 00/01/10/11 = 1/12.5/10/8 MHz
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "nvol_defines.vh"

module nvol_option_loader #(
    parameter SETTLE_CYCLES = `NVOL_SETTLE_CYCLES
) (
    input wire clk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // flash option area read port
    output reg flash_rd_req,
    output reg [15:0] flash_addr,
    input wire [7:0] flash_rdata,
    input wire flash_rd_ack,
    // flash erase port
    output reg flash_erase_req,
    output reg flash_erase_option_area,
    input wire flash_erase_done,
    // standby indication from the power controller
    input wire standby_active,
    // watchdog selection
    output reg load_done,
    output reg hw_wdt_enable,
    output reg sw_wdt_enable,
    output reg hw_wdt_halt,
    // rc oscillator control
    output reg [1:0] rc_frequency_select,
    output reg [4:0] rc_trim_coarse,
    output reg [5:0] rc_trim_fine,
    output reg rc_reconfig,
    output reg rc_unstable
);

    // ==========================================================
    // load sequencer states
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_REQ = 6'b000010;
    localparam [5:0] S_WAIT = 6'b000100;
    localparam [5:0] S_NEXT = 6'b001000;
    localparam [5:0] S_DONE = 6'b010000;
    localparam [5:0] S_ERASE = 6'b100000;

    localparam [1:0] IDX_COARSE = 2'd0;
    localparam [1:0] IDX_FINE = 2'd1;
    localparam [1:0] IDX_HIGH = 2'd2;
    localparam [1:0] IDX_LOW = 2'd3;

    localparam integer SETTLE_W = 16;
    // counts above the counter width are cut on purpose; the analog settle is short
    localparam [31:0] SETTLE_FULL = SETTLE_CYCLES;
    localparam [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_FULL[SETTLE_W-1:0];
    localparam [SETTLE_W-1:0] SETTLE_ONE = {{(SETTLE_W-1){1'b0}}, 1'b1};

    reg [5:0] state;
    reg [5:0] next_state;
    reg [1:0] idx;
    reg [7:0] watchdog_select_key_high;
    reg [7:0] watchdog_select_key_low;
    reg [6:0] rc_trim_coarse_reg;
    reg [5:0] rc_trim_fine_reg;
    reg [SETTLE_W-1:0] settle_cnt;

    wire [5:0] reg_sel;
    wire reg_unmapped;
    wire setup_phase;
    wire wr_commit;
    wire key_hw_en;
    wire key_sw_en;
    wire key_halt;
    wire erase_go;
    reg [15:0] next_addr;
    reg [31:0] status_word;
    reg [31:0] next_prdata;
    wire [1:0] addr_idx;
    wire load_take;
    wire rc_change;

    // ==========================================================
    // address decode and key decode
    nvol_apb_decode u_decode (
        .paddr(paddr),
        .sel(reg_sel),
        .unmapped(reg_unmapped)
    );

    nvol_key_decode u_key (
        .key({watchdog_select_key_high, watchdog_select_key_low}),
        .hw_wdt_en(key_hw_en),
        .sw_wdt_en(key_sw_en),
        .hw_halt_in_standby(key_halt)
    );

    assign setup_phase = psel & ~penable;
    // a write takes effect only at the completing edge of the access phase
    assign wr_commit = psel & penable & pready & pwrite;
    assign erase_go = wr_commit & reg_sel[5] & pwdata[`NVOL_ERASE_GO] & (state == S_DONE);

    // in S_NEXT the index has not stepped yet, so address the byte after it
    assign addr_idx = (state == S_NEXT) ? idx + 2'd1 : idx;
    assign load_take = (state == S_WAIT) & flash_rd_ack;

    // ==========================================================
    // flash address for each load step
    always @* begin
        case (addr_idx)
            IDX_COARSE: next_addr = `NVOL_FADDR_COARSE;
            IDX_FINE: next_addr = `NVOL_FADDR_FINE;
            IDX_HIGH: next_addr = `NVOL_FADDR_KEY_HIGH;
            IDX_LOW: next_addr = `NVOL_FADDR_KEY_LOW;
            default: next_addr = `NVOL_FADDR_COARSE;
        endcase
    end

    // ==========================================================
    // sequencer next state
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: next_state = S_REQ;
            S_REQ: next_state = S_WAIT;
            S_WAIT: begin
                if (flash_rd_ack) begin
                    next_state = S_NEXT;
                end
            end
            S_NEXT: begin
                // one cycle with the request low lets the flash clear its ack
                if (idx == IDX_LOW) begin
                    next_state = S_DONE;
                end else begin
                    next_state = S_REQ;
                end
            end
            S_DONE: begin
                if (erase_go) begin
                    next_state = S_ERASE;
                end
            end
            S_ERASE: begin
                // the option area is blank now; reload it the same way as after reset
                if (flash_erase_done) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    // ==========================================================
    // sequencer and flash ports
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            idx <= IDX_COARSE;
            flash_rd_req <= 1'b0;
            flash_addr <= 16'h0000;
            flash_erase_req <= 1'b0;
            flash_erase_option_area <= 1'b0;
        end else begin
            state <= next_state;
            flash_rd_req <= (next_state == S_REQ) | (next_state == S_WAIT);
            flash_erase_req <= (next_state == S_ERASE);
            // erase always takes the option words with it
            flash_erase_option_area <= (next_state == S_ERASE);
            if (next_state == S_REQ) begin
                flash_addr <= next_addr;
            end
            if (state == S_NEXT) begin
                idx <= idx + 2'd1;
            end else if (state == S_ERASE) begin
                idx <= IDX_COARSE;
            end
        end
    end

    // ==========================================================
    // option registers: flash load, then software on the trim only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_select_key_high <= `NVOL_RST_KEY;
            watchdog_select_key_low <= `NVOL_RST_KEY;
            rc_trim_coarse_reg <= {`NVOL_RST_SEL, `NVOL_RST_COARSE};
            rc_trim_fine_reg <= `NVOL_RST_FINE;
        end else if (load_take) begin
            // bit 7 of the coarse byte is unused and never stored
            case (idx)
                IDX_COARSE: rc_trim_coarse_reg <= flash_rdata[6:0];
                IDX_FINE: rc_trim_fine_reg <= flash_rdata[5:0];
                IDX_HIGH: watchdog_select_key_high <= flash_rdata;
                IDX_LOW: watchdog_select_key_low <= flash_rdata;
                default: rc_trim_fine_reg <= rc_trim_fine_reg;
            endcase
        end else if (wr_commit && state == S_DONE) begin
            // key registers have no write path at all
            // trim writes live only here and never reach flash
            if (reg_sel[2]) begin
                rc_trim_coarse_reg <= pwdata[6:0];
            end
            if (reg_sel[3]) begin
                rc_trim_fine_reg <= pwdata[5:0];
            end
        end
    end

    // ==========================================================
    // watchdog selection outputs, held safe until the load completes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            load_done <= 1'b0;
            hw_wdt_enable <= 1'b0;
            sw_wdt_enable <= 1'b0;
            hw_wdt_halt <= 1'b0;
        end else begin
            load_done <= (state == S_DONE);
            // a half-loaded key must pick no watchdog at all
            if (state == S_DONE) begin
                hw_wdt_enable <= key_hw_en;
                sw_wdt_enable <= key_sw_en;
                hw_wdt_halt <= key_hw_en & key_halt & standby_active;
            end else begin
                hw_wdt_enable <= 1'b0;
                sw_wdt_enable <= 1'b0;
                hw_wdt_halt <= 1'b0;
            end
        end
    end

    // ==========================================================
    // rc oscillator control
    // trim code maps monotonically: 0 is fastest, all ones slowest
    // select code 00/01/10/11 is decoded by the analog block as 1/12.5/10/8 MHz
    // any difference between the software copy and the live outputs is a change
    assign rc_change =
        (rc_trim_coarse_reg[`NVOL_SEL_MSB:`NVOL_SEL_LSB] != rc_frequency_select) |
        (rc_trim_coarse_reg[4:0] != rc_trim_coarse) |
        (rc_trim_fine_reg != rc_trim_fine);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rc_frequency_select <= `NVOL_RST_SEL;
            rc_trim_coarse <= `NVOL_RST_COARSE;
            rc_trim_fine <= `NVOL_RST_FINE;
            rc_reconfig <= 1'b0;
            rc_unstable <= 1'b0;
            settle_cnt <= {SETTLE_W{1'b0}};
        end else begin
            rc_reconfig <= 1'b0;
            if (state == S_DONE) begin
                rc_frequency_select <= rc_trim_coarse_reg[`NVOL_SEL_MSB:`NVOL_SEL_LSB];
                rc_trim_coarse <= rc_trim_coarse_reg[4:0];
                rc_trim_fine <= rc_trim_fine_reg;
                if (rc_change) begin
                    // software should have moved the cpu clock away first
                    rc_reconfig <= 1'b1;
                    rc_unstable <= 1'b1;
                    // a further change restarts the settle count
                    settle_cnt <= SETTLE_LOAD;
                end else if (settle_cnt != {SETTLE_W{1'b0}}) begin
                    settle_cnt <= settle_cnt - SETTLE_ONE;
                end else begin
                    rc_unstable <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // status word; each flag sits at its defined bit position
    always @* begin
        status_word = 32'h00000000;
        status_word[`NVOL_ST_DONE] = load_done;
        status_word[`NVOL_ST_HW_WDT] = hw_wdt_enable;
        status_word[`NVOL_ST_SW_WDT] = sw_wdt_enable;
        status_word[`NVOL_ST_HW_HALT] = hw_wdt_halt;
        status_word[`NVOL_ST_UNSTABLE] = rc_unstable;
        status_word[`NVOL_ST_ERASING] = (state == S_ERASE);
    end

    // ==========================================================
    // read data for the register picked in the setup phase
    // writes and unmapped reads return zero so stale data never leaks
    always @* begin
        next_prdata = 32'h00000000;
        if (!pwrite) begin
            case (1'b1)
                reg_sel[0]: next_prdata = {24'h000000, watchdog_select_key_high};
                reg_sel[1]: next_prdata = {24'h000000, watchdog_select_key_low};
                reg_sel[2]: next_prdata = {25'h0000000, rc_trim_coarse_reg};
                reg_sel[3]: next_prdata = {26'h0000000, rc_trim_fine_reg};
                reg_sel[4]: next_prdata = status_word;
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // apb slave: zero wait states, read data captured in setup
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                pslverr <= reg_unmapped;
                prdata <= next_prdata;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule

// File: nvol_defines.vh
// Purpose: constants for the nonvolatile option loader
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: definitions only
`ifndef NVOL_DEFINES_VH
`define NVOL_DEFINES_VH

// ==========================================================
// flash option area addresses
`define NVOL_FADDR_COARSE 16'hFFBC
`define NVOL_FADDR_FINE 16'hFFBD
`define NVOL_FADDR_KEY_HIGH 16'hFFBE
`define NVOL_FADDR_KEY_LOW 16'hFFBF

// ==========================================================
// watchdog selection keys
`define NVOL_KEY_SOFT 16'hA596
`define NVOL_KEY_HARD_STOP 16'hA597

// ==========================================================
// register byte offsets
`define NVOL_OFF_KEY_HIGH 8'h00
`define NVOL_OFF_KEY_LOW 8'h04
`define NVOL_OFF_TRIM_COARSE 8'h08
`define NVOL_OFF_TRIM_FINE 8'h0C
`define NVOL_OFF_STATUS 8'h10
`define NVOL_OFF_ERASE 8'h14

// ==========================================================
// field positions and widths
`define NVOL_COARSE_W 5
`define NVOL_FINE_W 6
`define NVOL_SEL_LSB 5
`define NVOL_SEL_MSB 6
`define NVOL_ST_DONE 0
`define NVOL_ST_HW_WDT 1
`define NVOL_ST_SW_WDT 2
`define NVOL_ST_HW_HALT 3
`define NVOL_ST_UNSTABLE 4
`define NVOL_ST_ERASING 5
`define NVOL_ERASE_GO 0

// ==========================================================
// reset values and timing
`define NVOL_RST_SEL 2'h0
`define NVOL_RST_COARSE 5'h00
`define NVOL_RST_FINE 6'h00
`define NVOL_RST_KEY 8'h00
`define NVOL_SETTLE_CYCLES 64

`endif

// File: nvol_apb_decode.v
// Purpose: apb address decode for the option loader registers
// Assumes: paddr holds a byte address, word aligned
// Notes: purely combinational, sampled by the top in the setup phase
`timescale 1ns/100ps
`include "nvol_defines.vh"

module nvol_apb_decode (
    input wire [7:0] paddr,
    output reg [5:0] sel,
    output reg unmapped
);
    // one bit per register, in offset order
    always @* begin
        sel = 6'h00;
        unmapped = 1'b0;
        case (paddr)
            `NVOL_OFF_KEY_HIGH: sel = 6'h01;
            `NVOL_OFF_KEY_LOW: sel = 6'h02;
            `NVOL_OFF_TRIM_COARSE: sel = 6'h04;
            `NVOL_OFF_TRIM_FINE: sel = 6'h08;
            `NVOL_OFF_STATUS: sel = 6'h10;
            `NVOL_OFF_ERASE: sel = 6'h20;
            default: unmapped = 1'b1;
        endcase
    end
endmodule

// File: nvol_key_decode.v
// Purpose: watchdog selection from the 16-bit key
// Assumes: key is upper byte then lower byte
// Notes: combinational
`timescale 1ns/100ps
`include "nvol_defines.vh"

module nvol_key_decode (
    input wire [15:0] key,
    output reg hw_wdt_en,
    output reg sw_wdt_en,
    output reg hw_halt_in_standby
);
    always @* begin
        hw_wdt_en = 1'b1;
        sw_wdt_en = 1'b0;
        hw_halt_in_standby = 1'b0;
        if (key == `NVOL_KEY_SOFT) begin
            hw_wdt_en = 1'b0;
            sw_wdt_en = 1'b1;
        end else if (key == `NVOL_KEY_HARD_STOP) begin
            hw_halt_in_standby = 1'b1;
        end
        // any other key: hardware watchdog on, counts through standby
    end
endmodule

// File: nvol_option_loader_props.sv
// Purpose: port checks for the option loader
// Assumes: one clock, rst asynchronous active high
// Notes: bound from the bench top
`timescale 1ns/100ps
module nvol_option_loader_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic flash_rd_req,
    input wire logic [15:0] flash_addr,
    input wire logic flash_rd_ack,
    input wire logic flash_erase_req,
    input wire logic flash_erase_option_area,
    input wire logic flash_erase_done,
    input wire logic standby_active,
    input wire logic load_done,
    input wire logic hw_wdt_enable,
    input wire logic sw_wdt_enable,
    input wire logic hw_wdt_halt,
    input wire logic [4:0] rc_trim_coarse,
    input wire logic [5:0] rc_trim_fine,
    input wire logic rc_reconfig,
    input wire logic rc_unstable
);
    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wait;
        flash_rd_req && !flash_rd_ack;
    endsequence
    sequence s_take;
        flash_rd_req && flash_rd_ack;
    endsequence
    AST_WDT_GATED: assert property (!load_done |-> !hw_wdt_enable && !sw_wdt_enable)
        else $error("watchdog on before load");
    AST_WDT_ONE: assert property (load_done |-> hw_wdt_enable ^ sw_wdt_enable)
        else $error("watchdog selection not exclusive");
    AST_HALT: assert property (hw_wdt_halt |-> hw_wdt_enable && $past(standby_active))
        else $error("halt without cause");
    AST_ERASE_AREA: assert property (flash_erase_req == flash_erase_option_area)
        else $error("erase skips option area");
    AST_REQ_HOLD: assert property (s_wait |=> flash_rd_req && $stable(flash_addr))
        else $error("read request dropped");
    AST_REQ_DROP: assert property (s_take |=> !flash_rd_req)
        else $error("read request held after ack");
    AST_UNSTABLE: assert property (rc_reconfig |-> rc_unstable)
        else $error("no unstable flag on change");
    AST_RECONF: assert property ($changed(rc_trim_coarse) |-> rc_reconfig)
        else $error("trim change without pulse");
    sequence s_erase_end;
        flash_erase_req && flash_erase_done;
    endsequence
    AST_RELOAD: assert property (s_erase_end |-> ##[1:8] flash_rd_req)
        else $error("no reload after erase");
endmodule

// File: nvol_flash_model.sv
// Purpose: flash option area seen from the loader
// Assumes: read ack after wait_cycles plus one cycles of request, erase takes 8 cycles
// Notes: contents survive rst, as flash does
`timescale 1ns/100ps
module nvol_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] wait_cycles,
    input wire logic flash_rd_req,
    input wire logic [15:0] flash_addr,
    input wire logic flash_erase_req,
    output logic [7:0] flash_rdata,
    output logic flash_rd_ack,
    output logic flash_erase_done
);
    logic [7:0] mem [0:3];
    logic [3:0] cnt;
    logic [3:0] ecnt;
    int i;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            ecnt <= 4'h0;
            flash_rd_ack <= 1'b0;
            flash_erase_done <= 1'b0;
            flash_rdata <= 8'h00;
        end else begin
            flash_rd_ack <= 1'b0;
            flash_erase_done <= 1'b0;
            // idle data toggles so stale bytes are never mistaken for valid
            flash_rdata <= ~flash_rdata;
            if (flash_rd_req && !flash_rd_ack) begin
                cnt <= cnt + 4'h1;
                if (cnt == wait_cycles) begin
                    cnt <= 4'h0;
                    flash_rd_ack <= 1'b1;
                    flash_rdata <= mem[flash_addr[1:0]];
                end
            end
            if (flash_erase_req && !flash_erase_done) begin
                ecnt <= ecnt + 4'h1;
                if (ecnt == 4'h7) begin
                    ecnt <= 4'h0;
                    flash_erase_done <= 1'b1;
                    for (i = 0; i < 4; i++) begin
                        mem[i] <= 8'hFF;
                    end
                end
            end
        end
    end
endmodule

// File: nonvolatile_option_loader_tb_top.sv
// Purpose: self-checking bench for the option loader
// Assumes: apb master, flash model on the far side
// Notes: settle count shortened to 4
`timescale 1ns/100ps
module nonvolatile_option_loader_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic standby_active = 1'b0;
    logic [3:0] wait_cycles = 4'h5;
    wire [31:0] prdata;
    wire pready, pslverr, flash_rd_req, flash_rd_ack, flash_erase_req;
    wire flash_erase_option_area, flash_erase_done, load_done, rc_reconfig;
    wire hw_wdt_enable, sw_wdt_enable, hw_wdt_halt, rc_unstable;
    wire [15:0] flash_addr;
    wire [7:0] flash_rdata;
    wire [1:0] rc_frequency_select;
    wire [4:0] rc_trim_coarse;
    wire [5:0] rc_trim_fine;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int i;
    nvol_option_loader #(.SETTLE_CYCLES(4)) dut (
        .clk(clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .flash_rd_req(flash_rd_req),
        .flash_addr(flash_addr),
        .flash_rdata(flash_rdata),
        .flash_rd_ack(flash_rd_ack),
        .flash_erase_req(flash_erase_req),
        .flash_erase_option_area(flash_erase_option_area),
        .flash_erase_done(flash_erase_done),
        .standby_active(standby_active),
        .load_done(load_done),
        .hw_wdt_enable(hw_wdt_enable),
        .sw_wdt_enable(sw_wdt_enable),
        .hw_wdt_halt(hw_wdt_halt),
        .rc_frequency_select(rc_frequency_select),
        .rc_trim_coarse(rc_trim_coarse),
        .rc_trim_fine(rc_trim_fine),
        .rc_reconfig(rc_reconfig),
        .rc_unstable(rc_unstable)
    );
    nvol_flash_model flash (
        .clk(clk),
        .rst(rst),
        .wait_cycles(wait_cycles),
        .flash_rd_req(flash_rd_req),
        .flash_addr(flash_addr),
        .flash_erase_req(flash_erase_req),
        .flash_rdata(flash_rdata),
        .flash_rd_ack(flash_rd_ack),
        .flash_erase_done(flash_erase_done)
    );
    always #20 clk = ~clk;
    // ==========================================
    // common tasks
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude;
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_load;
        while (load_done !== 1'b1) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    // ==========================================
    // scenarios
    task t_load;
        apb(0, 8'h00, 0);
        chk("key_high", rd, 32'hA5);
        apb(0, 8'h04, 0);
        chk("key_low", rd, 32'h97);
        apb(0, 8'h08, 0);
        chk("coarse_reg", rd, 32'h5F);
        apb(0, 8'h0C, 0);
        chk("fine_reg", rd, 32'h3F);
        chk("select", rc_frequency_select, 2'h2);
        chk("coarse", rc_trim_coarse, 5'h1F);
        chk("fine", rc_trim_fine, 6'h3F);
        apb(0, 8'h10, 0);
        chk("status", rd, 32'h03);
        $display("test load done");
    endtask
    task t_readonly;
        apb(1, 8'h00, 32'h12);
        apb(1, 8'h04, 32'h34);
        chk("ro_err", er, 1'b0);
        apb(0, 8'h00, 0);
        chk("key_high_ro", rd, 32'hA5);
        apb(0, 8'h04, 0);
        chk("key_low_ro", rd, 32'h97);
        apb(0, 8'h18, 0);
        chk("unmapped_err", er, 1'b1);
        $display("test readonly done");
    endtask
    task t_trim;
        // the cpu clock is taken to run from another source during these edits
        apb(1, 8'h08, 32'h20);
        apb(0, 8'h08, 0);
        chk("coarse_wr", rd, 32'h20);
        chk("select_wr", rc_frequency_select, 2'h1);
        chk("unstable", rc_unstable, 1'b1);
        apb(1, 8'h0C, 32'h0);
        repeat (8) @(posedge clk);
        chk("settled", rc_unstable, 1'b0);
        chk("max_freq", {rc_trim_coarse, rc_trim_fine}, 11'h0);
        chk("no_writeback", flash.mem[0], 8'h5F);
        $display("test trim done");
    endtask
    task t_erase;
        standby_active <= 1'b1;
        apb(1, 8'h14, 32'h1);
        repeat (3) @(posedge clk);
        chk("erase_req", flash_erase_req, 1'b1);
        while (!(flash_rd_ack === 1'b1 && flash_addr === 16'hFFBF)) @(posedge clk);
        wait_load;
        apb(0, 8'h00, 0);
        chk("erased_key", rd, 32'hFF);
        apb(0, 8'h08, 0);
        chk("erased_trim", rd, 32'h7F);
        chk("wdt_other", {hw_wdt_enable, sw_wdt_enable, hw_wdt_halt}, 3'b100);
        // a programmer restores the saved trim after the erase
        flash.mem[0] = 8'h5F;
        flash.mem[1] = 8'h3F;
        $display("test erase done");
    endtask
    task t_keys;
        logic [15:0] key [0:2];
        logic [2:0] exp [0:2];
        key = '{16'hA596, 16'hA597, 16'hA598};
        exp = '{3'b010, 3'b101, 3'b100};
        for (i = 0; i < 3; i++) begin
            flash.mem[2] = key[i][15:8];
            flash.mem[3] = key[i][7:0];
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
            wait_load;
            chk("wdt_sel", {hw_wdt_enable, sw_wdt_enable, hw_wdt_halt}, exp[i]);
        end
        chk("restored", {rc_frequency_select, rc_trim_coarse}, 7'h5F);
        $display("test keys done");
    endtask
    initial begin
        flash.mem[0] = 8'h5F;
        flash.mem[1] = 8'h3F;
        flash.mem[2] = 8'hA5;
        flash.mem[3] = 8'h97;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wait_load;
        t_load;
        t_readonly;
        t_trim;
        wait_cycles <= 4'h0;
        t_erase;
        t_keys;
        conclude;
    end
endmodule
bind nvol_option_loader nvol_option_loader_props u_props (
    .clk(clk),
    .rst(rst),
    .flash_rd_req(flash_rd_req),
    .flash_addr(flash_addr),
    .flash_rd_ack(flash_rd_ack),
    .flash_erase_req(flash_erase_req),
    .flash_erase_option_area(flash_erase_option_area),
    .flash_erase_done(flash_erase_done),
    .standby_active(standby_active),
    .load_done(load_done),
    .hw_wdt_enable(hw_wdt_enable),
    .sw_wdt_enable(sw_wdt_enable),
    .hw_wdt_halt(hw_wdt_halt),
    .rc_trim_coarse(rc_trim_coarse),
    .rc_trim_fine(rc_trim_fine),
    .rc_reconfig(rc_reconfig),
    .rc_unstable(rc_unstable)
);
